// ==== hw/csdc_pkg.sv ====
package csdc_pkg;
  // Time base
  localparam int CLK_KHZ     = 10000;
  localparam int CNT_SLOW_US = 16700;
  localparam int CNT_FAST_US = 100;
  localparam int OS_LONG_MS  = 500;
  localparam int OS_SHORT_MS = 50;
  localparam int RST_SLOW_MS = 20;
  localparam int RST_FAST_MS = 1;
  localparam int HOLD_MS     = 1000;
  localparam logic [23:0] CNT_SLOW_CYC = 24'((CNT_SLOW_US*CLK_KHZ+999)/1000);
  localparam logic [23:0] CNT_FAST_CYC = 24'((CNT_FAST_US*CLK_KHZ+999)/1000);
  localparam logic [23:0] OS_LONG_CYC  = 24'(OS_LONG_MS*CLK_KHZ);
  localparam logic [23:0] OS_SHORT_CYC = 24'(OS_SHORT_MS*CLK_KHZ);
  localparam logic [23:0] RST_SLOW_CYC = 24'(RST_SLOW_MS*CLK_KHZ);
  localparam logic [23:0] RST_FAST_CYC = 24'(RST_FAST_MS*CLK_KHZ);
  localparam logic [23:0] HOLD_CYC     = 24'(HOLD_MS*CLK_KHZ);
  // Register offsets and reset values
  localparam logic [3:0]  A_KEY   = 4'h0;
  localparam logic [3:0]  A_AUX   = 4'h4;
  localparam logic [3:0]  A_STAT  = 4'h8;
  localparam logic [10:0] KEY_RST = 11'h000;
  localparam logic [4:0]  AUX_RST = 5'h00;
  // Switch positions, position 1 at bit 0
  localparam int DIP_EN = 0, DIP_RATE = 1, DIP_DIR = 2, DIP_OM0 = 3;
  localparam int DIP_OM1 = 4, DIP_OS = 5, DIP_RW = 6, DIP_POL = 7;
  // Input channels
  localparam int CH_CP1 = 0, CH_CP2 = 1, CH_RST1 = 2, CH_RST2 = 3;
  // Input modes
  localparam logic [2:0] IN_INC = 3'h0, IN_DEC = 3'h1, IN_UDA = 3'h2;
  localparam logic [2:0] IN_UDB = 3'h3, IN_UDC = 3'h4;
  // Output modes; codes 4 to 11 are key-only modes
  localparam logic [3:0] OM_N = 4'h0, OM_F = 4'h1, OM_C = 4'h2;
  localparam logic [3:0] OM_K1 = 4'h3;
  // Personalities
  localparam logic [2:0] P_ONE = 3'h0, P_TWO = 3'h1, P_TOT = 3'h2;
  localparam logic [2:0] P_BAT = 3'h3, P_DUAL = 3'h4, P_TACH = 3'h5;
  localparam int         P_NUM = 6;
  // Display selection
  localparam logic [1:0] D_PV = 2'h0, D_TOT = 2'h1, D_BAT = 2'h2;
  // Tacho averaging and comparison
  localparam logic [1:0] AVG_OFF = 2'h0, AVG_2 = 2'h1;
  localparam logic [1:0] AVG_4 = 2'h2, AVG_8 = 2'h3;
  localparam logic [1:0] TACHO_HIGH_LOW_COMPARE   = 2'h0;
  localparam logic [1:0] TACHO_WINDOW_COMPARE     = 2'h1;
  localparam logic [1:0] TACHO_DUAL_UPPER_COMPARE = 2'h2;
  localparam logic [1:0] TACHO_DUAL_LOWER_COMPARE = 2'h3;

  typedef enum logic [1:0] {K_IDLE, K_ARMED, K_HOLD, K_CFG} csdc_key_t;

  typedef struct packed {
    logic       fast;
    logic [2:0] in_mode;
    logic [3:0] out_mode;
    logic       os_short;
    logic       rst_short;
    logic       pnp;
  } csdc_cfg_t;

  typedef struct packed {
    logic       fast;
    logic [1:0] avg;
    logic [1:0] cmp;
  } csdc_tacho_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } csdc_req_t;
endpackage

// ==== hw/csdc_top.sv ====
`timescale 1ns/10ps
module csdc_top #(
  parameter logic [5:0]  SUPPORT   = 6'h3f,
  parameter logic        TWO_STAGE = 1'b1,
  parameter logic [23:0] CNT_SLOW  = csdc_pkg::CNT_SLOW_CYC,
  parameter logic [23:0] OS_LONG   = csdc_pkg::OS_LONG_CYC,
  parameter logic [23:0] OS_SHORT  = csdc_pkg::OS_SHORT_CYC,
  parameter logic [23:0] RST_SLOW  = csdc_pkg::RST_SLOW_CYC,
  parameter logic [23:0] RST_FAST  = csdc_pkg::RST_FAST_CYC,
  parameter logic [23:0] HOLD      = csdc_pkg::HOLD_CYC
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  SRST,
  input  wire csdc_pkg::csdc_req_t   REQ,
  output logic [31:0]                RDATA,
  input  wire logic [7:0]            DIP_SW,
  input  wire logic [3:0]            IN_RAW,
  input  wire logic                  KEY_MODE,
  input  wire logic                  KEY_UP1,
  input  wire logic                  KEY_RESET,
  input  wire logic [1:0]            DISP_SEL,
  input  wire logic                  NV_VALID,
  input  wire logic [2:0]            NV_PERS,
  output logic                       NV_WR,
  output logic [2:0]                 NV_WDATA,
  input  wire logic [23:0]           CP1_PV,
  input  wire logic [23:0]           CP2_PV,
  output logic [23:0]                DUAL_VAL,
  output logic [3:0]                 IN_ACT,
  output csdc_pkg::csdc_cfg_t        CFG,
  output csdc_pkg::csdc_tacho_t      TACHO,
  output logic [2:0]                 PERSONA,
  output logic                       CFG_SEL_MODE,
  output logic                       READY,
  output logic [23:0]                ONESHOT_CYC,
  output logic                       LED_RST,
  output logic                       LED_TOT,
  output logic                       LED_BAT
);
  import csdc_pkg::*;

  typedef struct packed {
    logic            sampled;
    logic [7:0]      dip;
    logic [2:0]      pers;
    csdc_key_t       fsm;
    logic [23:0]     hold_cnt;
    logic            up_q;
    logic            mode_q;
    logic [3:0]      filt;
    logic [3:0][23:0] fcnt;
    logic [10:0]     key_reg;
    logic [4:0]      aux_reg;
    csdc_cfg_t       cfg;
    logic [31:0]     rdata;
    logic [23:0]     dual;
    logic            led_rst;
    logic            led_tot;
    logic            led_bat;
    logic            nv_wr;
  } csdc_st_t;

  csdc_st_t st;
  csdc_st_t next_st;

  logic [2:0]  dflt_pers;
  logic [23:0] cnt_lim;
  logic [23:0] rst_lim;
  logic        up_rise;
  logic        mode_rise;

  // Skip unsupported personalities, wrapping after the tachometer
  function automatic logic [2:0] adv_pers(input logic [2:0] p,
                                          input logic [5:0] m);
    logic [2:0] r;
    logic [2:0] c;
    r = p;
    for (int k = P_NUM; k >= 1; k--) begin
      c = 3'((int'(p) + k) % P_NUM);
      if (m[c]) begin
        r = c;
      end
    end
    return r;
  endfunction

  assign dflt_pers = (TWO_STAGE && SUPPORT[P_TWO]) ? P_TWO : P_ONE;
  assign cnt_lim   = st.cfg.fast ? CNT_FAST_CYC : CNT_SLOW;
  assign rst_lim   = st.cfg.rst_short ? RST_FAST : RST_SLOW;
  assign up_rise   = KEY_UP1 && !st.up_q;
  assign mode_rise = KEY_MODE && !st.mode_q;

  always_comb begin
    next_st        = st;
    next_st.nv_wr  = 1'b0;
    next_st.rdata  = 32'h0;
    next_st.up_q   = KEY_UP1;
    next_st.mode_q = KEY_MODE;

    // One capture after reset release stands for power-on
    if (!st.sampled) begin
      next_st.sampled = 1'b1;
      next_st.dip     = DIP_SW;
      if (NV_VALID && int'(NV_PERS) < P_NUM && SUPPORT[NV_PERS]) begin
        next_st.pers = NV_PERS;
      end else begin
        next_st.pers = dflt_pers;
      end
    end

    // Until the capture, dip holds zero and key settings govern
    if (st.dip[DIP_EN]) begin
      next_st.cfg.fast      = st.dip[DIP_RATE];
      next_st.cfg.in_mode   = st.dip[DIP_DIR] ? IN_DEC : IN_INC;
      next_st.cfg.out_mode  = {2'b00, st.dip[DIP_OM1], st.dip[DIP_OM0]};
      next_st.cfg.os_short  = st.dip[DIP_OS];
      next_st.cfg.rst_short = st.dip[DIP_RW];
      next_st.cfg.pnp       = st.dip[DIP_POL];
    end else begin
      next_st.cfg = csdc_cfg_t'(st.key_reg);
    end

    // Edge is accepted only after the level has held for the full width
    for (int i = 0; i < 4; i++) begin
      logic act;
      logic [23:0] lim;
      act = st.cfg.pnp ? IN_RAW[i] : !IN_RAW[i];
      lim = (i < 2) ? cnt_lim : rst_lim;
      if (act == st.filt[i]) begin
        next_st.fcnt[i] = 24'h0;
      end else if (st.fcnt[i] >= lim - 24'h1) begin
        next_st.filt[i] = act;
        next_st.fcnt[i] = 24'h0;
      end else begin
        next_st.fcnt[i] = st.fcnt[i] + 24'h1;
      end
    end

    case (st.fsm)
      K_IDLE: begin
        // Up held first keeps us here until it is released
        if (KEY_MODE && !KEY_UP1) begin
          next_st.fsm = K_ARMED;
        end
      end
      K_ARMED: begin
        if (!KEY_MODE) begin
          next_st.fsm = K_IDLE;
        end else if (KEY_UP1) begin
          next_st.fsm      = K_HOLD;
          next_st.hold_cnt = 24'h0;
        end
      end
      K_HOLD: begin
        if (!KEY_MODE || !KEY_UP1) begin
          next_st.fsm = K_IDLE;
        end else if (st.hold_cnt >= HOLD - 24'h1) begin
          next_st.fsm = K_CFG;
        end else begin
          next_st.hold_cnt = st.hold_cnt + 24'h1;
        end
      end
      K_CFG: begin
        if (mode_rise) begin
          next_st.fsm   = K_IDLE;
          next_st.nv_wr = 1'b1;
        end else if (up_rise) begin
          next_st.pers = adv_pers(st.pers, SUPPORT);
        end
      end
      default: begin
        next_st.fsm = K_IDLE;
      end
    endcase

    if (REQ.wr) begin
      case (REQ.addr)
        A_KEY:   next_st.key_reg = REQ.wdata[10:0];
        A_AUX:   next_st.aux_reg = REQ.wdata[4:0];
        default: next_st.key_reg = st.key_reg;
      endcase
    end
    if (REQ.rd) begin
      case (REQ.addr)
        A_KEY:   next_st.rdata = {21'h0, st.key_reg};
        A_AUX:   next_st.rdata = {27'h0, st.aux_reg};
        A_STAT:  next_st.rdata = {19'h0, st.dip, st.dip[DIP_EN],
                                  st.fsm == K_CFG, st.pers};
        default: next_st.rdata = 32'h0;
      endcase
    end

    // Wraps in 24 bits; the core keeps values inside the display range
    if (st.aux_reg[0]) begin
      next_st.dual = CP1_PV - CP2_PV;
    end else begin
      next_st.dual = CP1_PV + CP2_PV;
    end

    next_st.led_rst = st.filt[CH_RST1] || KEY_RESET;
    next_st.led_tot = st.pers == P_TOT && DISP_SEL == D_TOT;
    next_st.led_bat = st.pers == P_BAT && DISP_SEL == D_BAT;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st         <= '0;
      st.fsm     <= K_IDLE;
      st.pers    <= P_ONE;
      st.key_reg <= KEY_RST;
      st.aux_reg <= AUX_RST;
    end else begin
      st <= next_st;
    end
  end

  assign RDATA        = st.rdata;
  assign NV_WR        = st.nv_wr;
  assign NV_WDATA     = st.pers;
  assign DUAL_VAL     = st.dual;
  assign IN_ACT       = st.filt;
  assign CFG          = st.cfg;
  assign TACHO        = csdc_tacho_t'(st.aux_reg[4:0]);
  assign PERSONA      = st.pers;
  assign CFG_SEL_MODE = st.fsm == K_CFG;
  assign READY        = st.sampled;
  assign ONESHOT_CYC  = st.cfg.os_short ? OS_SHORT : OS_LONG;
  assign LED_RST      = st.led_rst;
  assign LED_TOT      = st.led_tot;
  assign LED_BAT      = st.led_bat;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  sequence s_mode_then_up;
    st.fsm == K_ARMED && KEY_MODE && KEY_UP1;
  endsequence
  sequence s_hold_done;
    st.fsm == K_HOLD && KEY_MODE && KEY_UP1 && st.hold_cnt == HOLD - 24'h1;
  endsequence

  chk_dip_ignored: assert property (
    st.sampled && !st.dip[DIP_EN] |=> CFG == $past(st.key_reg))
    else $error("key settings not applied with switch disabled");
  chk_rate_dir: assert property (
    st.dip[DIP_EN] |=> CFG.fast == $past(st.dip[DIP_RATE]) &&
      CFG.in_mode == ($past(st.dip[DIP_DIR]) ? IN_DEC : IN_INC))
    else $error("rate or direction not taken from switch");
  chk_out_mode: assert property (
    st.dip[DIP_EN] && st.dip[DIP_OM0] && !st.dip[DIP_OM1]
      |=> CFG.out_mode == OM_F)
    else $error("position 4 alone did not give mode F");
  chk_oneshot_time: assert property (
    st.dip[DIP_EN] ##1 st.dip[DIP_EN] |->
      ONESHOT_CYC == ($past(st.dip[DIP_OS]) ? OS_SHORT : OS_LONG))
    else $error("one-shot time does not follow position 6");
  chk_dip_frozen: assert property (
    st.sampled |=> $stable(st.dip) && st.sampled)
    else $error("switch value changed after power-up capture");
  chk_hold_start: assert property (
    s_mode_then_up |=> st.fsm == K_HOLD && st.hold_cnt == 24'h0)
    else $error("hold timing did not start");
  chk_hold_enter: assert property (
    s_hold_done |=> CFG_SEL_MODE)
    else $error("selection not entered after hold time");
  chk_early_entry: assert property (
    $rose(CFG_SEL_MODE) |-> $past(st.hold_cnt) == HOLD - 24'h1)
    else $error("selection entered before hold time");
  chk_up_first: assert property (
    st.fsm == K_IDLE && KEY_UP1 |=> st.fsm == K_IDLE && !CFG_SEL_MODE)
    else $error("entry allowed with up key pressed first");
  chk_pers_adv: assert property (
    CFG_SEL_MODE && up_rise && !mode_rise
      |=> SUPPORT[PERSONA] && PERSONA == adv_pers($past(PERSONA), SUPPORT))
    else $error("personality step wrong");
  chk_dual_calc: assert property (
    1'b1 |=> DUAL_VAL == ($past(st.aux_reg[0]) ?
      $past(CP1_PV) - $past(CP2_PV) : $past(CP1_PV) + $past(CP2_PV)))
    else $error("dual value wrong");
  chk_reset_lamp: assert property (
    st.filt[CH_RST1] || KEY_RESET |=> LED_RST)
    else $error("reset lamp not lit");
  chk_total_lamp: assert property (
    LED_TOT |-> $past(st.pers) == P_TOT && $past(DISP_SEL) == D_TOT)
    else $error("total lamp lit without total display");
  chk_batch_lamp: assert property (
    LED_BAT |-> $past(st.pers) == P_BAT && $past(DISP_SEL) == D_BAT)
    else $error("batch lamp lit without batch display");
  chk_count_filt: assert property (
    $changed(IN_ACT[CH_CP1]) |-> $past(st.fcnt[CH_CP1]) == cnt_lim - 24'h1)
    else $error("count input accepted at wrong width");
  chk_nv_store: assert property (
    CFG_SEL_MODE && mode_rise |=> NV_WR && NV_WDATA == $past(PERSONA)
      && !CFG_SEL_MODE)
    else $error("personality not stored on leaving selection");

  // Decoder, power-up, key, lamp, filter and bus corners that the bench reaches only partly
  chk_mode_n: assert property (
    st.dip[DIP_EN] && !st.dip[DIP_OM0] && !st.dip[DIP_OM1]
      |=> CFG.out_mode == OM_N)
    else $error("positions 4 and 5 off did not give mode N");
  chk_mode_c: assert property (
    st.dip[DIP_EN] && !st.dip[DIP_OM0] && st.dip[DIP_OM1]
      |=> CFG.out_mode == OM_C)
    else $error("position 5 alone did not give mode C");
  chk_mode_k1: assert property (
    st.dip[DIP_EN] && st.dip[DIP_OM0] && st.dip[DIP_OM1]
      |=> CFG.out_mode == OM_K1)
    else $error("positions 4 and 5 on did not give mode K-1");
  chk_reset_width: assert property (
    st.dip[DIP_EN] |=> CFG.rst_short == $past(st.dip[DIP_RW]))
    else $error("reset width does not follow position 7");
  chk_polarity: assert property (
    st.dip[DIP_EN] |=> CFG.pnp == $past(st.dip[DIP_POL]))
    else $error("polarity does not follow position 8");
  chk_sw_modes: assert property (
    st.dip[DIP_EN] |=> (CFG.in_mode == IN_INC || CFG.in_mode == IN_DEC)
      && CFG.out_mode[3:2] == 2'b00)
    else $error("switch reached a key-only mode");
  chk_dip_capture: assert property (
    !st.sampled |=> st.dip == $past(DIP_SW) && READY)
    else $error("switch not captured after power-up");
  chk_default_pers: assert property (
    !st.sampled && !NV_VALID |=> PERSONA == dflt_pers)
    else $error("default personality wrong");
  chk_nv_restore: assert property (
    !st.sampled && NV_VALID && NV_PERS <= P_TACH && SUPPORT[NV_PERS]
      |=> PERSONA == $past(NV_PERS))
    else $error("stored personality not restored");
  chk_pers_hold: assert property (
    st.sampled && !CFG_SEL_MODE |=> $stable(PERSONA))
    else $error("personality moved outside selection");
  chk_hold_abort: assert property (
    st.fsm == K_HOLD && !(KEY_MODE && KEY_UP1) |=> st.fsm == K_IDLE)
    else $error("hold not abandoned on key release");
  chk_lamp_off: assert property (
    !st.filt[CH_RST1] && !KEY_RESET |=> !LED_RST)
    else $error("reset lamp lit without reset");
  chk_total_on: assert property (
    st.pers == P_TOT && DISP_SEL == D_TOT |=> LED_TOT)
    else $error("total lamp dark while total shown");
  chk_rst_filt: assert property (
    $changed(IN_ACT[CH_RST1]) |-> $past(st.fcnt[CH_RST1]) == rst_lim - 24'h1)
    else $error("reset input accepted at wrong width");
  chk_key_write: assert property (
    REQ.wr && REQ.addr == A_KEY |=> st.key_reg == $past(REQ.wdata[10:0]))
    else $error("key register write lost");
  chk_aux_write: assert property (
    REQ.wr && REQ.addr == A_AUX |=> st.aux_reg == $past(REQ.wdata[4:0]))
    else $error("aux register write lost");
  chk_stat_ro: assert property (
    REQ.wr && REQ.addr == A_STAT |=> $stable(st.key_reg) && $stable(st.aux_reg))
    else $error("status write changed a register");
  chk_read_idle: assert property (
    !REQ.rd |=> RDATA == 32'h0)
    else $error("read data not zero outside read");
endmodule

// ==== bench/csdc_far_model.sv ====
`timescale 1ns/10ps
module csdc_far_model (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic        nv_wr,
  input  wire logic [2:0]  nv_wdata,
  output logic             nv_valid,
  output logic [2:0]       nv_pers,
  output logic [23:0]      cp1,
  output logic [23:0]      cp2
);
  // Store is never cleared by reset, like a real nonvolatile part
  initial begin
    nv_valid = 1'b0;
    nv_pers  = 3'h6;
    cp1      = 24'h000010;
    cp2      = 24'h000020;
  end
  always @(posedge clk) begin
    if (nv_wr) begin
      nv_valid <= 1'b1;
      nv_pers  <= nv_wdata;
    end
    // Channel two starts ahead so a difference goes negative
    if (run) begin
      cp1 <= cp1 + 24'h000007;
      cp2 <= cp2 + 24'h000003;
    end
  end
endmodule

// ==== bench/tb_counter_setup_dip_config.sv ====
`timescale 1ns/10ps
module tb_counter_setup_dip_config;
  import csdc_pkg::*;
  localparam int         CNT_T = 20, OSL_T = 50, OSS_T = 5;
  localparam int         RSL_T = 30, RSF_T = 8, HOLD_T = 16;
  localparam logic [5:0] SUP = 6'h2f;
  logic        clk_sys, srst, key_mode, key_up1, key_reset, run;
  logic        nv_valid, nv_wr, cfg_sel_mode, ready;
  logic        led_rst, led_tot, led_bat;
  logic [1:0]  disp_sel;
  logic [2:0]  nv_pers, nv_wdata, persona;
  logic [3:0]  in_raw, in_act;
  logic [7:0]  dip_sw;
  logic [23:0] cp1_pv, cp2_pv, dual_val, oneshot_cyc;
  logic [31:0] rdata;
  csdc_req_t   req;
  csdc_cfg_t   cfg;
  csdc_tacho_t tacho;
  int          fails, n_checks;

  csdc_top #(.SUPPORT(SUP), .TWO_STAGE(1'b1), .CNT_SLOW(24'(CNT_T)),
    .OS_LONG(24'(OSL_T)), .OS_SHORT(24'(OSS_T)), .RST_SLOW(24'(RSL_T)),
    .RST_FAST(24'(RSF_T)), .HOLD(24'(HOLD_T))) csdc_top_inst (
    .CLK_SYS(clk_sys), .SRST(srst), .REQ(req), .RDATA(rdata),
    .DIP_SW(dip_sw), .IN_RAW(in_raw), .KEY_MODE(key_mode),
    .KEY_UP1(key_up1), .KEY_RESET(key_reset), .DISP_SEL(disp_sel),
    .NV_VALID(nv_valid), .NV_PERS(nv_pers), .NV_WR(nv_wr),
    .NV_WDATA(nv_wdata), .CP1_PV(cp1_pv), .CP2_PV(cp2_pv),
    .DUAL_VAL(dual_val), .IN_ACT(in_act), .CFG(cfg), .TACHO(tacho),
    .PERSONA(persona), .CFG_SEL_MODE(cfg_sel_mode), .READY(ready),
    .ONESHOT_CYC(oneshot_cyc), .LED_RST(led_rst), .LED_TOT(led_tot),
    .LED_BAT(led_bat));
  csdc_far_model csdc_far_model_inst (.clk(clk_sys), .run(run),
    .nv_wr(nv_wr), .nv_wdata(nv_wdata), .nv_valid(nv_valid),
    .nv_pers(nv_pers), .cp1(cp1_pv), .cp2(cp2_pv));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic settle(input int n);
    cyc(n);
    #1;
  endtask

  // Reset stands in for a power cycle, so the switch is recaptured
  task automatic power_up(input logic [7:0] sw);
    @(posedge clk_sys);
    dip_sw <= sw;
    srst <= 1'b1;
    cyc(10);
    srst <= 1'b0;
    settle(4);
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_on(input int sel, input int lim, output int n);
    n = 0;
    do begin
      settle(1);
      n++;
    end while ((sel == 0 ? cfg_sel_mode : nv_wr) !== 1'b1 && n < lim);
    if ((sel == 0 ? cfg_sel_mode : nv_wr) !== 1'b1) begin
      fails++;
      $display("BAD wait %0d expected 1 seen 0", sel);
      finish_test();
    end
  endtask

  function automatic csdc_cfg_t sw_cfg(input logic [7:0] s);
    sw_cfg.fast = s[DIP_RATE];
    sw_cfg.in_mode = s[DIP_DIR] ? IN_DEC : IN_INC;
    sw_cfg.out_mode = {2'b00, s[DIP_OM1], s[DIP_OM0]};
    sw_cfg.os_short = s[DIP_OS];
    sw_cfg.rst_short = s[DIP_RW];
    sw_cfg.pnp = s[DIP_POL];
  endfunction

  function automatic int nxt(input int p);
    nxt = (p + 1) % P_NUM;
    if (!SUP[nxt]) nxt = (nxt + 1) % P_NUM;
  endfunction

  task automatic t_switch;
    logic [7:0]  tbl [9] = '{8'h00, 8'h01, 8'h0b, 8'h15, 8'h19, 8'h21,
                             8'h41, 8'h81, 8'hff};
    logic [31:0] s;
    csdc_cfg_t   e;
    foreach (tbl[i]) begin
      power_up(tbl[i]);
      e = tbl[i][DIP_EN] ? sw_cfg(tbl[i]) : csdc_cfg_t'(KEY_RST);
      chk("cfg", 32'(e), 32'(cfg));
      chk("os", e.os_short ? OSS_T : OSL_T, 32'(oneshot_cyc));
      chk("ready", 32'h1, 32'(ready));
      bus_rd(A_STAT, s);
      chk("stat", {19'h0, tbl[i], tbl[i][0], 1'b0, P_TWO}, s);
    end
    $display("Test switch done");
  endtask

  task automatic t_keys;
    csdc_cfg_t   k;
    logic [31:0] s;
    k = '{1'b1, IN_UDB, 4'h9, 1'b1, 1'b0, 1'b1};
    power_up(8'hfe);
    bus_wr(A_KEY, 32'(k));
    settle(3);
    chk("key cfg", 32'(k), 32'(cfg));
    bus_rd(A_KEY, s);
    chk("key reg", 32'(k), s);
    bus_wr(A_STAT, 32'hffffffff);
    bus_rd(A_STAT, s);
    chk("stat ro", 32'h1fc, 32'(s[12:4]));
    bus_rd(4'hc, s);
    chk("unmapped", 32'h0, s);
    settle(1);
    chk("rd idle", 32'h0, rdata);
    power_up(8'h05);
    bus_wr(A_KEY, 32'(k));
    @(posedge clk_sys);
    dip_sw <= 8'h03;
    settle(5);
    chk("live sw", 32'(sw_cfg(8'h05)), 32'(cfg));
    power_up(8'h03);
    chk("new sw", 32'(sw_cfg(8'h03)), 32'(cfg));
    $display("Test keys done");
  endtask

  task automatic t_dual;
    logic [23:0] d;
    for (int i = 0; i < 4; i++) begin
      bus_wr(A_AUX, 32'({i[0], i[1:0], i[1:0]}));
      run <= 1'b1;
      @(posedge clk_sys);
      run <= 1'b0;
      settle(3);
      d = i[0] ? cp1_pv - cp2_pv : cp1_pv + cp2_pv;
      chk("tacho", 32'({i[0], i[1:0], i[1:0]}), 32'(tacho));
      chk("dual", 32'(d), 32'(dual_val));
    end
    $display("Test dual done");
  endtask

  task automatic pulse(input int ch, input int n, input logic [3:0] idle);
    @(posedge clk_sys);
    in_raw <= idle ^ (4'h1 << ch);
    cyc(n);
    in_raw <= idle;
    settle(1);
  endtask

  task automatic t_filter;
    logic [3:0] idle;
    for (int p = 0; p < 2; p++) begin
      idle = p[0] ? 4'h0 : 4'hf;
      @(posedge clk_sys);
      in_raw <= idle;
      power_up({p[0], ~p[0], 6'h01});
      pulse(0, CNT_T - 4, idle);
      settle(3);
      chk("glitch", 32'h0, 32'(in_act[0]));
      pulse(0, CNT_T + 3, idle);
      chk("count", 32'h1, 32'(in_act[0]));
      pulse(2, (p ? RSL_T : RSF_T) + 3, idle);
      chk("rst in", 32'h1, 32'(in_act[2]));
      chk("rst lamp", 32'h1, 32'(led_rst));
      settle(RSL_T + 4);
      chk("lamp off", 32'h0, 32'(led_rst));
      @(posedge clk_sys);
      key_reset <= 1'b1;
      settle(2);
      chk("key lamp", 32'h1, 32'(led_rst));
      @(posedge clk_sys);
      key_reset <= 1'b0;
    end
    $display("Test filter done");
  endtask

  task automatic t_select;
    int n;
    int e;
    power_up(8'h00);
    @(posedge clk_sys);
    key_up1 <= 1'b1;
    cyc(2);
    key_mode <= 1'b1;
    settle(HOLD_T + 6);
    chk("up first", 32'h0, 32'(cfg_sel_mode));
    @(posedge clk_sys);
    key_up1 <= 1'b0;
    key_mode <= 1'b0;
    cyc(3);
    key_mode <= 1'b1;
    cyc(3);
    key_up1 <= 1'b1;
    wait_on(0, HOLD_T + 8, n);
    chk("hold", 32'h1, 32'(n >= HOLD_T));
    e = P_TWO;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      key_up1 <= 1'b0;
      cyc(2);
      key_up1 <= 1'b1;
      settle(2);
      e = nxt(e);
      chk("persona", 32'(e), 32'(persona));
      for (int d = 0; d < 3; d++) begin
        @(posedge clk_sys);
        disp_sel <= 2'(d);
        settle(2);
        chk("tot lamp", 32'(e == P_TOT && d == 1), 32'(led_tot));
        chk("bat lamp", 32'(e == P_BAT && d == 2), 32'(led_bat));
      end
    end
    @(posedge clk_sys);
    key_mode <= 1'b0;
    cyc(3);
    key_mode <= 1'b1;
    wait_on(1, 8, n);
    chk("store", 32'(e), 32'(nv_wdata));
    settle(2);
    chk("leave", 32'h0, 32'(cfg_sel_mode));
    @(posedge clk_sys);
    key_mode <= 1'b0;
    key_up1 <= 1'b0;
    power_up(8'h00);
    chk("restore", 32'(e), 32'(persona));
    $display("Test select done");
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    req = '0;
    dip_sw = 8'h00;
    in_raw = 4'hf;
    {key_mode, key_up1, key_reset, run} = 4'h0;
    disp_sel = 2'h0;
    fails = 0;
    n_checks = 0;
    t_switch();
    t_keys();
    t_dual();
    t_filter();
    t_select();
    finish_test();
  end
endmodule
